// [hw/power_mode_consts.svh]
// Constants for the power-mode controller: widths, fields, resets and timing
//
// Summary of operation
// - Exactly five power states, each own settings
// - Reset/power-up enters full-on, PLL not bypassed
// - Active: PLL bypassed, both clocks enabled
// - Active still grants DMA to local memory
// - Sleep: core clock off, PLL and system run
// - Sleep refuses system DMA to local memory
// - Deep sleep: PLL off, both clocks off
// - Deep sleep blocks asynchronous peripherals' accesses
// - Deep sleep exits only by reset or GPIO
// - Zero-volt supply request from full-on, active or sleep enters hibernate, power off
// - Hibernate bit written zero drops regulator wake
// - Hibernate puts external pins into high impedance
// - Regulator control register survives hibernate
// - Other state is invalid after hibernate wake
// - Per-peripheral clock gating under software control
// - Regulator wake output high requests core power
// - Reset in hibernate raises regulator wake output
// - Startup waits for active-low power-good after hibernate
`ifndef POWER_MODE_CONSTS_SVH
`define POWER_MODE_CONSTS_SVH

// ============================================================
// Regulator control register
`define VR_WIDTH          16
`define VR_HIBERNATE_BIT  15
`define VR_RESET_VALUE    16'h8000

// ============================================================
// Timing
`define CLK_PERIOD_NS     40
`define WAKE_MIN_NS       10
`define WAKE_MIN_CYCLES   (((`WAKE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                           ((`WAKE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define SYNC_STAGES       2

`endif

// [hw/power_mode_pkg.sv]
// Types shared by the power-mode controller
package power_mode_pkg;

    // Gray coded along full-on, active, sleep, deep sleep, hibernate
    typedef enum logic [2:0] {
        ST_FULL_ON    = 3'h0,
        ST_ACTIVE     = 3'h1,
        ST_SLEEP      = 3'h3,
        ST_DEEP_SLEEP = 3'h2,
        ST_HIBERNATE  = 3'h6
    } power_state_t;

endpackage

// [hw/wake_sync.sv]
// Two-stage synchroniser and level match for the GPIO wake input
`timescale 1ns/10ps

module wake_sync
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic gpio_wake_pin,
    input  wire logic wake_level,
    output logic      wake_hit
);

    logic [1:0] sync_ff;
    logic [1:0] nxt_sync;
    logic       hit_ff;
    logic       nxt_hit;

    // ============================================================
    // Next values; only the second stage is compared
    always_comb
    begin
        nxt_sync = {sync_ff[0], gpio_wake_pin};
        nxt_hit  = (sync_ff[1] == wake_level);
    end

    // ============================================================
    // Registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sync_ff <= 2'h0;
            hit_ff  <= 1'h0;
        end
        else
        begin
            sync_ff <= nxt_sync;
            hit_ff  <= nxt_hit;
        end
    end

    assign wake_hit = hit_ff;

endmodule

// [hw/power_mode_controller.sv]
// Power-mode controller: state sequencing, clock gating, DMA and regulator control
`timescale 1ns/10ps
`include "power_mode_consts.svh"

module power_mode_controller
#(
    parameter int NUM_PERIPH = 8
)
(
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   io_por,
    input  wire logic [2:0]             mode_req,
    input  wire logic                   mode_req_valid,
    input  wire logic                   active_pll_off,
    input  wire logic                   sleep_wake_event,
    input  wire logic                   gpio_wake_pin,
    input  wire logic                   gpio_wake_level,
    input  wire logic                   vr_wr_en,
    input  wire logic [`VR_WIDTH-1:0]   vr_wr_data,
    input  wire logic                   power_good_in_n,
    input  wire logic [NUM_PERIPH-1:0]  periph_clk_on,
    input  wire logic                   dma_l1_req,
    input  wire logic                   lost_ack,
    output logic [2:0]                  power_state,
    output logic                        pll_en,
    output logic                        pll_bypass,
    output logic                        core_clock_en,
    output logic                        sys_clock_en,
    output logic                        core_power_on,
    output logic [NUM_PERIPH-1:0]       periph_clk_en,
    output logic                        dma_l1_grant,
    output logic                        async_periph_block,
    output logic                        pins_hiz,
    output logic                        regulator_wake_out,
    output logic [`VR_WIDTH-1:0]        regulator_control_register,
    output logic                        context_lost
);

    // ============================================================
    // Declarations
    power_mode_pkg::power_state_t state_ff;
    power_mode_pkg::power_state_t nxt_state;
    logic                  gpio_hit;
    logic                  hib_req;
    logic                  supply_hold;
    logic [`VR_WIDTH-1:0]  vr_ff;
    logic [`VR_WIDTH-1:0]  nxt_vr;
    logic                  wake_out_ff;
    logic                  nxt_wake_out;
    logic                  from_hib_ff;
    logic                  nxt_from_hib;
    logic                  pll_en_ff;
    logic                  nxt_pll_en;
    logic                  bypass_ff;
    logic                  nxt_bypass;
    logic                  core_en_ff;
    logic                  nxt_core_en;
    logic                  sys_en_ff;
    logic                  nxt_sys_en;
    logic                  cpwr_ff;
    logic                  nxt_cpwr;
    logic [NUM_PERIPH-1:0] periph_ff;
    logic [NUM_PERIPH-1:0] nxt_periph;
    logic                  grant_ff;
    logic                  nxt_grant;
    logic                  ablock_ff;
    logic                  nxt_ablock;
    logic                  hiz_ff;
    logic                  nxt_hiz;
    logic                  lost_ff;
    logic                  nxt_lost;

    // Map a requested mode code to a legal software target; hibernate goes by regulator write
    function automatic power_mode_pkg::power_state_t decode_req
    (
        input logic [2:0]                   code,
        input power_mode_pkg::power_state_t cur
    );
        power_mode_pkg::power_state_t res;
        res = cur;
        if (code == power_mode_pkg::ST_FULL_ON)
            res = power_mode_pkg::ST_FULL_ON;
        else if (code == power_mode_pkg::ST_ACTIVE)
            res = power_mode_pkg::ST_ACTIVE;
        else if (code == power_mode_pkg::ST_SLEEP)
            res = power_mode_pkg::ST_SLEEP;
        else if (code == power_mode_pkg::ST_DEEP_SLEEP)
            res = power_mode_pkg::ST_DEEP_SLEEP;
        return res;
    endfunction

    // ============================================================
    // GPIO wake synchroniser
    wake_sync u_wake_sync
    (
        .core_clk      (core_clk),
        .rst           (rst),
        .gpio_wake_pin (gpio_wake_pin),
        .wake_level    (gpio_wake_level),
        .wake_hit      (gpio_hit)
    );

    // Hibernate request is a regulator write with the hibernate bit cleared
    assign hib_req = vr_wr_en && !vr_wr_data[`VR_HIBERNATE_BIT];
    // After a hibernate wake no mode request is taken and core and system clocks stay off until the supply is good
    assign supply_hold = from_hib_ff && power_good_in_n;

    // ============================================================
    // Power state sequencing
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            power_mode_pkg::ST_FULL_ON,
            power_mode_pkg::ST_ACTIVE:
            begin
                if (hib_req)
                    nxt_state = power_mode_pkg::ST_HIBERNATE;
                else if (mode_req_valid && !supply_hold)
                    nxt_state = decode_req(mode_req, state_ff);
            end
            power_mode_pkg::ST_SLEEP:
            begin
                if (hib_req)
                    nxt_state = power_mode_pkg::ST_HIBERNATE;
                else if (sleep_wake_event || gpio_hit)
                    nxt_state = power_mode_pkg::ST_FULL_ON;
            end
            power_mode_pkg::ST_DEEP_SLEEP:
            begin
                // Only a synchronised GPIO wake leaves; reset acts asynchronously
                if (gpio_hit)
                    nxt_state = power_mode_pkg::ST_FULL_ON;
            end
            power_mode_pkg::ST_HIBERNATE:
            begin
                // Held until the reset pin restarts everything outside the retained domain
                nxt_state = power_mode_pkg::ST_HIBERNATE;
            end
            default:
            begin
                nxt_state = power_mode_pkg::ST_FULL_ON;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state_ff <= power_mode_pkg::ST_FULL_ON;
        else
            state_ff <= nxt_state;
    end

    // ============================================================
    // Retained domain: lives on the I/O supply, so only io_por clears it
    always_comb
    begin
        nxt_vr       = vr_ff;
        nxt_from_hib = from_hib_ff;
        if (vr_wr_en)
            nxt_vr = vr_wr_data;
        // Reset pin in hibernate asks the regulator for core power again
        if (rst)
            nxt_vr[`VR_HIBERNATE_BIT] = 1'b1;
        // Remember hibernation across the reset that ends it
        if (state_ff == power_mode_pkg::ST_HIBERNATE)
            nxt_from_hib = 1'b1;
        else if (!power_good_in_n && !rst)
            nxt_from_hib = 1'b0;
        nxt_wake_out = nxt_vr[`VR_HIBERNATE_BIT];
    end

    always_ff @(posedge core_clk or posedge io_por)
    begin
        if (io_por)
        begin
            vr_ff       <= `VR_RESET_VALUE;
            wake_out_ff <= 1'b1;
            from_hib_ff <= 1'b0;
        end
        else
        begin
            vr_ff       <= nxt_vr;
            wake_out_ff <= nxt_wake_out;
            from_hib_ff <= nxt_from_hib;
        end
    end

    // ============================================================
    // Per-state settings; all enables change on a clock edge, or asynchronously when rst is asserted
    always_comb
    begin
        nxt_pll_en  = 1'b0;
        nxt_bypass  = 1'b0;
        nxt_core_en = 1'b0;
        nxt_sys_en  = 1'b0;
        nxt_cpwr    = 1'b1;
        nxt_ablock  = 1'b0;
        nxt_hiz     = 1'b0;
        case (nxt_state)
            power_mode_pkg::ST_FULL_ON:
            begin
                nxt_pll_en  = 1'b1;
                nxt_core_en = 1'b1;
                nxt_sys_en  = 1'b1;
            end
            power_mode_pkg::ST_ACTIVE:
            begin
                nxt_pll_en  = !active_pll_off;
                nxt_bypass  = 1'b1;
                nxt_core_en = 1'b1;
                nxt_sys_en  = 1'b1;
            end
            power_mode_pkg::ST_SLEEP:
            begin
                nxt_pll_en = 1'b1;
                nxt_sys_en = 1'b1;
            end
            power_mode_pkg::ST_DEEP_SLEEP:
            begin
                nxt_ablock = 1'b1;
            end
            power_mode_pkg::ST_HIBERNATE:
            begin
                nxt_cpwr   = 1'b0;
                nxt_ablock = 1'b1;
                nxt_hiz    = 1'b1;
            end
            default:
            begin
                nxt_cpwr = 1'b1;
            end
        endcase
        // After a hibernate wake, core and system clocks stay stopped while the regulator is still ramping
        if (supply_hold)
        begin
            nxt_core_en = 1'b0;
            nxt_sys_en  = 1'b0;
        end
        nxt_periph = periph_clk_on & {NUM_PERIPH{nxt_sys_en}};
        // Local-memory DMA only while the core clock domain runs
        nxt_grant = dma_l1_req && nxt_core_en;
    end

    // ============================================================
    // Context-lost flag; a hibernate wake with the supply good beats a same-cycle ack
    always_comb
    begin
        nxt_lost = lost_ff;
        if (lost_ack)
            nxt_lost = 1'b0;
        if (from_hib_ff && !supply_hold)
            nxt_lost = 1'b1;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pll_en_ff  <= 1'b1;
            bypass_ff  <= 1'b0;
            core_en_ff <= 1'b0;
            sys_en_ff  <= 1'b0;
            cpwr_ff    <= 1'b1;
            periph_ff  <= '0;
            grant_ff   <= 1'b0;
            ablock_ff  <= 1'b0;
            hiz_ff     <= 1'b0;
            lost_ff    <= 1'b0;
        end
        else
        begin
            pll_en_ff  <= nxt_pll_en;
            bypass_ff  <= nxt_bypass;
            core_en_ff <= nxt_core_en;
            sys_en_ff  <= nxt_sys_en;
            cpwr_ff    <= nxt_cpwr;
            periph_ff  <= nxt_periph;
            grant_ff   <= nxt_grant;
            ablock_ff  <= nxt_ablock;
            hiz_ff     <= nxt_hiz;
            lost_ff    <= nxt_lost;
        end
    end

    // ============================================================
    // Outputs, each straight from a flip-flop
    assign power_state                = state_ff;
    assign pll_en                     = pll_en_ff;
    assign pll_bypass                 = bypass_ff;
    assign core_clock_en              = core_en_ff;
    assign sys_clock_en               = sys_en_ff;
    assign core_power_on              = cpwr_ff;
    assign periph_clk_en              = periph_ff;
    assign dma_l1_grant               = grant_ff;
    assign async_periph_block         = ablock_ff;
    assign pins_hiz                   = hiz_ff;
    assign regulator_wake_out         = wake_out_ff;
    assign regulator_control_register = vr_ff;
    assign context_lost               = lost_ff;

endmodule

// [tb/power_mode_checker_assertions.sv]
// Port-level assertions for the power-mode controller
`timescale 1ns/10ps
`include "power_mode_consts.svh"

module power_mode_checker
#(
    parameter int NUM_PERIPH = 8
)
(
    input wire logic                  core_clk,
    input wire logic                  rst,
    input wire logic                  io_por,
    input wire logic                  gpio_wake_pin,
    input wire logic                  gpio_wake_level,
    input wire logic                  vr_wr_en,
    input wire logic [`VR_WIDTH-1:0]  vr_wr_data,
    input wire logic                  power_good_in_n,
    input wire logic [NUM_PERIPH-1:0] periph_clk_on,
    input wire logic                  dma_l1_req,
    input wire logic [2:0]            power_state,
    input wire logic                  pll_en,
    input wire logic                  pll_bypass,
    input wire logic                  core_clock_en,
    input wire logic                  sys_clock_en,
    input wire logic                  core_power_on,
    input wire logic [NUM_PERIPH-1:0] periph_clk_en,
    input wire logic                  dma_l1_grant,
    input wire logic                  async_periph_block,
    input wire logic                  pins_hiz,
    input wire logic                  regulator_wake_out,
    input wire logic                  context_lost
);
    // ============================================================
    // Clocking and helper terms
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst || io_por);

    logic wake_match;

    // Pin sits at its programmed wake level
    assign wake_match = (gpio_wake_pin == gpio_wake_level);

    // ============================================================
    // Settings per state
    property p_full_on;
        power_state == 3'h0 |-> pll_en && !pll_bypass;
    endproperty
    a_full_on:
        assert property (p_full_on) else $error("full-on settings wrong");
    property p_active;
        power_state == 3'h1 |-> pll_bypass && core_clock_en && sys_clock_en;
    endproperty
    a_active:
        assert property (p_active) else $error("active settings wrong");
    property p_active_dma;
        power_state == 3'h1 && $past(dma_l1_req) |-> dma_l1_grant;
    endproperty
    a_active_dma:
        assert property (p_active_dma) else $error("active dma refused");
    property p_sleep;
        power_state == 3'h3 |-> !core_clock_en && sys_clock_en && pll_en && !dma_l1_grant;
    endproperty
    a_sleep:
        assert property (p_sleep) else $error("sleep settings wrong");
    property p_deep;
        power_state == 3'h2 |-> !pll_en && !core_clock_en && !sys_clock_en
            && core_power_on && async_periph_block;
    endproperty
    a_deep:
        assert property (p_deep) else $error("deep sleep settings wrong");
    // Only a synchronised pin match may end deep sleep
    property p_deep_exit;
        $past(power_state) == 3'h2 && power_state != 3'h2 |-> $past(wake_match, 2);
    endproperty
    a_deep_exit:
        assert property (p_deep_exit) else $error("deep sleep left without wake");
    property p_hib;
        power_state == 3'h6 |-> pins_hiz && !core_power_on && !core_clock_en && !sys_clock_en;
    endproperty
    a_hib:
        assert property (p_hib) else $error("hibernate settings wrong");
    property p_hib_bit;
        vr_wr_en && !vr_wr_data[15] |-> ##2 !regulator_wake_out;
    endproperty
    a_hib_bit:
        assert property (p_hib_bit) else $error("wake output did not drop");
    // Reset itself is the trigger, so only the supply reset masks it
    property p_wake_up;
        disable iff (io_por) $rose(rst) && !regulator_wake_out |-> ##[1:3] regulator_wake_out;
    endproperty
    a_wake_up:
        assert property (p_wake_up) else $error("reset did not raise wake output");
    property p_power_good;
        $rose(context_lost) |-> !$past(power_good_in_n) && core_clock_en;
    endproperty
    a_power_good:
        assert property (p_power_good) else $error("start before power good");
    property p_periph;
        periph_clk_en == ($past(periph_clk_on) & {NUM_PERIPH{sys_clock_en}});
    endproperty
    a_periph:
        assert property (p_periph) else $error("peripheral clock gate wrong");

    // ============================================================
    // Main scenarios reached
    c_sleep: cover property (power_state == 3'h3);
    c_deep_wake: cover property (power_state == 3'h2 ##1 power_state == 3'h0);
    c_hib: cover property (power_state == 3'h6 && !regulator_wake_out);
endmodule

bind power_mode_controller power_mode_checker #(.NUM_PERIPH(NUM_PERIPH)) u_chk (
    .core_clk, .rst, .io_por, .gpio_wake_pin, .gpio_wake_level, .vr_wr_en, .vr_wr_data,
    .power_good_in_n, .periph_clk_on, .dma_l1_req, .power_state, .pll_en, .pll_bypass,
    .core_clock_en, .sys_clock_en, .core_power_on, .periph_clk_en, .dma_l1_grant,
    .async_periph_block, .pins_hiz, .regulator_wake_out, .context_lost);

// [tb/core_regulator_model.sv]
// Behavioural external core-supply regulator
`timescale 1ns/10ps

module core_regulator_model
#(
    parameter int RAMP_CYCLES = 8
)
(
    input  wire logic core_clk,
    input  wire logic regulator_wake_out,
    output logic      power_good_in_n
);
    int ramp;

    // ============================================================
    // Supply starts unsettled
    initial
    begin
        power_good_in_n = 1'b1;
        ramp = 0;
    end

    // Shutdown drops power good at once; power-up needs a settling ramp
    always @(posedge core_clk)
    begin
        if (regulator_wake_out !== 1'b1)
        begin
            ramp <= 0;
            power_good_in_n <= 1'b1;
        end
        else if (ramp < RAMP_CYCLES)
            ramp <= ramp + 1;
        else
            power_good_in_n <= 1'b0;
    end
endmodule

// [tb/power_mode_controller_tb.sv]
// Self-checking bench for the power-mode controller
`timescale 1ns/10ps
`include "power_mode_consts.svh"

module power_mode_controller_tb;
    logic                 core_clk, rst, io_por, mode_req_valid, active_pll_off;
    logic                 sleep_wake_event, gpio_wake_pin, gpio_wake_level, vr_wr_en;
    logic                 power_good_in_n, dma_l1_req, lost_ack;
    logic [2:0]           mode_req, power_state;
    logic [`VR_WIDTH-1:0] vr_wr_data, regulator_control_register;
    logic [7:0]           periph_clk_on, periph_clk_en;
    logic                 pll_en, pll_bypass, core_clock_en, sys_clock_en, core_power_on;
    logic                 dma_l1_grant, async_periph_block, pins_hiz, regulator_wake_out;
    logic                 context_lost;
    int                   bad_count, compares;

    power_mode_controller #(.NUM_PERIPH(8)) uut (
        .core_clk, .rst, .io_por, .mode_req, .mode_req_valid, .active_pll_off,
        .sleep_wake_event, .gpio_wake_pin, .gpio_wake_level, .vr_wr_en, .vr_wr_data,
        .power_good_in_n, .periph_clk_on, .dma_l1_req, .lost_ack, .power_state, .pll_en,
        .pll_bypass, .core_clock_en, .sys_clock_en, .core_power_on, .periph_clk_en,
        .dma_l1_grant, .async_periph_block, .pins_hiz, .regulator_wake_out,
        .regulator_control_register, .context_lost);

    core_regulator_model #(.RAMP_CYCLES(8)) regulator (
        .core_clk, .regulator_wake_out, .power_good_in_n);

    // ============================================================
    // Clock and shared tasks
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic give_verdict;
        if (bad_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Inputs only move on the falling edge; an idle edge keeps pulses apart
    task automatic request(input logic [2:0] code);
        mode_req = code;
        mode_req_valid = 1'b1;
        step(1);
        mode_req_valid = 1'b0;
        step(1);
    endtask

    // Packed view: pll, core, sys, power, grant, block, hiz
    task automatic settings(input string name, input logic [6:0] exp);
        check(name, 16'({pll_en, core_clock_en, sys_clock_en, core_power_on,
            dma_l1_grant, async_periph_block, pins_hiz}), 16'(exp));
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset;
        check("state", 16'(power_state), 16'h0000);
        settings("full_on", 7'h7c);
        check("bypass", 16'(pll_bypass), 16'h0000);
        check("vr_reg", regulator_control_register, 16'h8000);
        check("wake_out", 16'(regulator_wake_out), 16'h0001);
        check("periph", 16'(periph_clk_en), 16'h00a5);
        periph_clk_on = 8'h3c;
        step(1);
        check("periph", 16'(periph_clk_en), 16'h003c);
        periph_clk_on = 8'ha5;
    endtask

    // Active with the PLL kept and then dropped, invalid code between
    task automatic t_active;
        request(3'h1);
        settings("active", 7'h7c);
        check("bypass", 16'(pll_bypass), 16'h0001);
        request(3'h7);
        check("state", 16'(power_state), 16'h0001);
        request(3'h0);
        check("bypass", 16'(pll_bypass), 16'h0000);
        active_pll_off = 1'b1;
        request(3'h1);
        settings("active_off", 7'h3c);
        request(3'h0);
        active_pll_off = 1'b0;
    endtask

    task automatic t_sleep;
        request(3'h3);
        settings("sleep", 7'h58);
        check("periph", 16'(periph_clk_en), 16'h00a5);
        request(3'h1);
        check("state", 16'(power_state), 16'h0003);
        sleep_wake_event = 1'b1;
        step(1);
        sleep_wake_event = 1'b0;
        check("state", 16'(power_state), 16'h0000);
        request(3'h3);
        gpio_wake_pin = 1'b0;
        step(4);
        check("state", 16'(power_state), 16'h0000);
        gpio_wake_pin = 1'b1;
        // Let the synchroniser see the idle level before deep sleep
        step(3);
    endtask

    // Wake level is low here, so the idle-high pin must not wake
    task automatic t_deep;
        int i;
        request(3'h2);
        settings("deep", 7'h0a);
        check("periph", 16'(periph_clk_en), 16'h0000);
        request(3'h0);
        sleep_wake_event = 1'b1;
        step(4);
        sleep_wake_event = 1'b0;
        check("state", 16'(power_state), 16'h0002);
        gpio_wake_pin = 1'b0;
        for (i = 0; i < 8 && power_state === 3'h2; i++)
            step(1);
        check("state", 16'(power_state), 16'h0000);
        gpio_wake_pin = 1'b1;
    endtask

    task automatic t_hibernate;
        int i;
        logic [15:0] saved;
        saved = regulator_control_register;
        vr_wr_data = 16'h1234;
        vr_wr_en = 1'b1;
        step(1);
        vr_wr_en = 1'b0;
        settings("hib", 7'h03);
        check("state", 16'(power_state), 16'h0006);
        step(1);
        check("wake_out", 16'(regulator_wake_out), 16'h0000);
        request(3'h0);
        step(4);
        check("state", 16'(power_state), 16'h0006);
        check("vr_reg", regulator_control_register, 16'h1234);
        rst = 1'b1;
        step(4);
        check("wake_out", 16'(regulator_wake_out), 16'h0001);
        check("vr_reg", regulator_control_register, 16'h9234);
        rst = 1'b0;
        step(1);
        check("core_en", 16'(core_clock_en), 16'h0000);
        request(3'h1);
        check("state", 16'(power_state), 16'h0000);
        for (i = 0; i < 20 && context_lost !== 1'b1; i++)
            step(1);
        check("lost", 16'(context_lost), 16'h0001);
        check("core_en", 16'(core_clock_en), 16'h0001);
        lost_ack = 1'b1;
        step(1);
        lost_ack = 1'b0;
        check("lost", 16'(context_lost), 16'h0000);
        // Software restores its saved copy; hibernate bit set keeps power on
        vr_wr_data = saved;
        vr_wr_en = 1'b1;
        step(1);
        vr_wr_en = 1'b0;
        check("vr_reg", regulator_control_register, 16'h8000);
        check("state", 16'(power_state), 16'h0000);
        check("wake_out", 16'(regulator_wake_out), 16'h0001);
    endtask

    // ============================================================
    // Main sequence and watchdog
    initial
    begin
        {mode_req, mode_req_valid, active_pll_off, sleep_wake_event} = '0;
        {gpio_wake_level, vr_wr_en, vr_wr_data, lost_ack} = '0;
        gpio_wake_pin = 1'b1;
        periph_clk_on = 8'ha5;
        dma_l1_req = 1'b1;
        rst = 1'b1;
        io_por = 1'b1;
        bad_count = 0;
        compares = 0;
        step(4);
        rst = 1'b0;
        io_por = 1'b0;
        step(1);
        t_reset();
        t_active();
        t_sleep();
        t_deep();
        t_hibernate();
        give_verdict();
    end

    // Run needs under a hundred cycles; this bound is far beyond that
    initial
    begin
        #(5000 * 40);
        bad_count++;
        give_verdict();
    end
endmodule
